// [verilog/usr_params.svh]
// Purpose: constants for the 4-bit universal shift register block
// Assumes: included by its bare name from the design file and the testbench
// Notes:   register offsets are byte addresses on the AXI4-Lite bus
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

// datapath and log buffer
`define USR_WIDTH        4
`define USR_MODE_W       2
`define USR_FIFO_DEPTH   16
`define USR_CLEAR_VAL    4'h0

// bus geometry and answers
`define USR_ADDR_W       8
`define USR_DATA_W       32
`define USR_RESP_OKAY    2'b00
`define USR_RESP_SLVERR  2'b10

// register offsets
`define USR_ADDR_CTRL    8'h00
`define USR_ADDR_STATE   8'h04
`define USR_ADDR_LOG     8'h08
`define USR_ADDR_LEVEL   8'h0c

// field positions
`define USR_CTRL_LOG_EN  0
`define USR_CTRL_LOST_CLR 1
`define USR_STATE_MODE   4
`define USR_LOG_VALID    8
`define USR_LEVEL_LOST   16

`endif

// [verilog/usr_pkg.sv]
// Purpose: shared types of the 4-bit universal shift register block
// Assumes: mode code is {mode_select_high, mode_select_low}
// Notes:   enum order follows that two-bit code
package usr_pkg;

   typedef enum logic [1:0] {
      USR_HOLD,
      USR_RIGHT,
      USR_LEFT,
      USR_LOAD
   } usr_mode_t;

endpackage

// [verilog/usr_shift.sv]
// Purpose: 4-bit bidirectional universal shift register with AXI4-Lite
//          status access and a log buffer of updates, taken while enabled and not full
// Assumes: all pins but async_clear_n synchronous to i_clock; clock_pulse is sampled, its
//          rising transition detected against the previous sample
// Notes:   async_clear_n clears the stored bits without a clock edge
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "usr_params.svh"

module usr_fifo #(
   parameter int WIDTH = `USR_WIDTH + `USR_MODE_W,
   parameter int DEPTH = `USR_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                     i_clock,
   input  wire logic                     i_rstn,
   // fill side
   input  wire logic                     i_in_valid,
   output logic                          o_in_ready,
   input  wire logic [WIDTH-1:0]         i_in_data,
   // drain side
   output logic                          o_out_valid,
   input  wire logic                     i_out_ready,
   output logic [WIDTH-1:0]              o_out_data,
   output logic [$clog2(DEPTH):0]        o_level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      level_r;
   logic             push;
   logic             pop;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
         $error("usr_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   assign o_in_ready  = (level_r != (AW+1)'(DEPTH));
   assign o_out_valid = (level_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];
   assign o_level     = level_r;
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_clock) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         level_r <= '0;
      end else if (push && !pop) begin
         level_r <= level_r + 1'b1;
      end else if (pop && !push) begin
         level_r <= level_r - 1'b1;
      end
   end

endmodule

module usr_shift_top #(
   parameter int WIDTH = `USR_WIDTH,
   parameter int DEPTH = `USR_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                     i_clock,
   input  wire logic                     i_rstn,
   // device pins
   input  wire logic                     i_async_clear_n,
   input  wire logic                     i_clock_pulse,
   input  wire logic                     i_mode_select_high,
   input  wire logic                     i_mode_select_low,
   input  wire logic                     i_serial_in_left,
   input  wire logic                     i_serial_in_right,
   input  wire logic [WIDTH-1:0]         i_load_inputs,
   output logic [WIDTH-1:0]              o_register_outputs,
   output logic                          o_log_ready,
   // axi4-lite write
   input  wire logic [`USR_ADDR_W-1:0]   i_s_axi_awaddr,
   input  wire logic                     i_s_axi_awvalid,
   output logic                          o_s_axi_awready,
   input  wire logic [`USR_DATA_W-1:0]   i_s_axi_wdata,
   input  wire logic [3:0]               i_s_axi_wstrb,
   input  wire logic                     i_s_axi_wvalid,
   output logic                          o_s_axi_wready,
   output logic [1:0]                    o_s_axi_bresp,
   output logic                          o_s_axi_bvalid,
   input  wire logic                     i_s_axi_bready,
   // axi4-lite read
   input  wire logic [`USR_ADDR_W-1:0]   i_s_axi_araddr,
   input  wire logic                     i_s_axi_arvalid,
   output logic                          o_s_axi_arready,
   output logic [`USR_DATA_W-1:0]        o_s_axi_rdata,
   output logic [1:0]                    o_s_axi_rresp,
   output logic                          o_s_axi_rvalid,
   input  wire logic                     i_s_axi_rready
);
   localparam int LW = WIDTH + `USR_MODE_W;
   localparam int CW = $clog2(DEPTH) + 1;

   generate
      // wider state would run into the mode field of the status word
      if (WIDTH < 2 || WIDTH > `USR_STATE_MODE) begin : g_width_chk
         $error("usr_shift_top: WIDTH must lie between 2 and 4");
      end
      if (CW > `USR_LEVEL_LOST) begin : g_level_chk
         $error("usr_shift_top: DEPTH too large for the level field");
      end
   endgenerate

   logic [WIDTH-1:0]        q_r;
   logic [WIDTH-1:0]        q_nxt;
   logic                    cp_prev_r;
   logic                    step;
   usr_pkg::usr_mode_t      mode;
   usr_pkg::usr_mode_t      last_mode_r;
   logic                    log_en_r;
   logic                    lost_r;
   logic                    lost_clr;
   logic                    log_ready_r;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic [LW-1:0]           fifo_out_data;
   logic [CW-1:0]           fifo_level;
   logic                    log_pop;
   logic                    aw_got_r;
   logic                    w_got_r;
   logic [`USR_ADDR_W-1:0]  awaddr_r;
   logic [`USR_DATA_W-1:0]  wdata_r;
   logic [3:0]              wstrb_r;
   logic                    wr_do;
   logic                    ar_take;
   logic [`USR_ADDR_W-1:0]  ar_word;
   logic [`USR_DATA_W-1:0]  rdata_nxt;
   logic [1:0]              rresp_nxt;

   // rising transition of the sampled clock pulse
   assign step = i_clock_pulse && !cp_prev_r;
   assign mode = usr_pkg::usr_mode_t'({i_mode_select_high, i_mode_select_low});

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         cp_prev_r <= 1'b0;
      end else begin
         cp_prev_r <= i_clock_pulse;
      end
   end

   // per-bit interstage mux
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic from_above;
         logic from_below;
         if (gi == WIDTH - 1) begin : g_top
            assign from_above = i_serial_in_left;
         end else begin : g_mid_a
            assign from_above = q_r[gi+1];
         end
         if (gi == 0) begin : g_bot
            assign from_below = i_serial_in_right;
         end else begin : g_mid_b
            assign from_below = q_r[gi-1];
         end
         always_comb begin
            unique case (mode)
               usr_pkg::USR_HOLD:  q_nxt[gi] = q_r[gi];
               usr_pkg::USR_LEFT:  q_nxt[gi] = from_above;
               usr_pkg::USR_RIGHT: q_nxt[gi] = from_below;
               usr_pkg::USR_LOAD:  q_nxt[gi] = i_load_inputs[gi];
            endcase
         end
      end
   endgenerate

   // storage, cleared by the pin without a clock
   always_ff @(posedge i_clock or negedge i_async_clear_n) begin
      if (!i_async_clear_n) begin
         q_r <= `USR_CLEAR_VAL;
      end else if (!i_rstn) begin
         q_r <= `USR_CLEAR_VAL;
      end else if (step) begin
         q_r <= q_nxt;
      end
   end

   assign o_register_outputs = q_r;

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         last_mode_r <= usr_pkg::USR_HOLD;
      end else if (step && i_async_clear_n) begin
         last_mode_r <= mode;
      end
   end

   // update log; a full buffer drops the entry and flags it
   usr_fifo #(
      .WIDTH (LW),
      .DEPTH (DEPTH)
   ) u_log (
      .i_clock     (i_clock),
      .i_rstn      (i_rstn),
      .i_in_valid  (step && log_en_r && i_async_clear_n),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({mode, q_nxt}),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (log_pop),
      .o_out_data  (fifo_out_data),
      .o_level     (fifo_level)
   );

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         log_ready_r <= 1'b0;
      end else begin
         log_ready_r <= fifo_in_ready;
      end
   end

   assign o_log_ready = log_ready_r;

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         lost_r <= 1'b0;
      end else if (step && log_en_r && i_async_clear_n && !fifo_in_ready) begin
         lost_r <= 1'b1;
      end else if (lost_clr) begin
         lost_r <= 1'b0;
      end
   end

   // write channel: address and data taken in either order
   assign wr_do    = aw_got_r && w_got_r && !o_s_axi_bvalid;
   assign lost_clr = wr_do && awaddr_r == `USR_ADDR_CTRL && wstrb_r[0]
                     && wdata_r[`USR_CTRL_LOST_CLR];

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         aw_got_r        <= 1'b0;
         awaddr_r        <= '0;
         o_s_axi_awready <= 1'b1;
      end else if (o_s_axi_awready && i_s_axi_awvalid) begin
         aw_got_r        <= 1'b1;
         awaddr_r        <= {i_s_axi_awaddr[`USR_ADDR_W-1:2], 2'b00};
         o_s_axi_awready <= 1'b0;
      end else if (wr_do) begin
         aw_got_r        <= 1'b0;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
         o_s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         w_got_r        <= 1'b0;
         wdata_r        <= '0;
         wstrb_r        <= '0;
         o_s_axi_wready <= 1'b1;
      end else if (o_s_axi_wready && i_s_axi_wvalid) begin
         w_got_r        <= 1'b1;
         wdata_r        <= i_s_axi_wdata;
         wstrb_r        <= i_s_axi_wstrb;
         o_s_axi_wready <= 1'b0;
      end else if (wr_do) begin
         w_got_r        <= 1'b0;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
         o_s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= `USR_RESP_OKAY;
      end else if (wr_do) begin
         o_s_axi_bvalid <= 1'b1;
         o_s_axi_bresp  <= (awaddr_r == `USR_ADDR_CTRL) ? `USR_RESP_OKAY
                                                        : `USR_RESP_SLVERR;
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         log_en_r <= 1'b0;
      end else if (wr_do && awaddr_r == `USR_ADDR_CTRL && wstrb_r[0]) begin
         log_en_r <= wdata_r[`USR_CTRL_LOG_EN];
      end
   end

   // read channel
   assign ar_take = o_s_axi_arready && i_s_axi_arvalid;
   assign ar_word = {i_s_axi_araddr[`USR_ADDR_W-1:2], 2'b00};
   assign log_pop = ar_take && ar_word == `USR_ADDR_LOG && fifo_out_valid;

   always_comb begin
      rdata_nxt = '0;
      rresp_nxt = `USR_RESP_OKAY;
      unique case (ar_word)
         `USR_ADDR_CTRL: begin
            rdata_nxt[`USR_CTRL_LOG_EN] = log_en_r;
         end
         `USR_ADDR_STATE: begin
            rdata_nxt[WIDTH-1:0] = q_r;
            rdata_nxt[`USR_STATE_MODE +: `USR_MODE_W] = last_mode_r;
         end
         `USR_ADDR_LOG: begin
            rdata_nxt[LW-1:0]          = fifo_out_valid ? fifo_out_data : '0;
            rdata_nxt[`USR_LOG_VALID]  = fifo_out_valid;
         end
         `USR_ADDR_LEVEL: begin
            rdata_nxt[CW-1:0]          = fifo_level;
            rdata_nxt[`USR_LEVEL_LOST] = lost_r;
         end
         default: begin
            rresp_nxt = `USR_RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= '0;
         o_s_axi_rresp   <= `USR_RESP_OKAY;
      end else if (ar_take) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid  <= 1'b1;
         o_s_axi_rdata   <= rdata_nxt;
         o_s_axi_rresp   <= rresp_nxt;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

   // checks on the shift datapath and the bus responses
   hold_keep_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      step && mode == usr_pkg::USR_HOLD |=> q_r == $past(q_r))
      else $error("hold mode changed the stored bits");

   shift_left_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      step && mode == usr_pkg::USR_LEFT
      |=> q_r == {$past(i_serial_in_left), $past(q_r[WIDTH-1:1])})
      else $error("shift left result wrong");

   shift_right_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      step && mode == usr_pkg::USR_RIGHT
      |=> q_r == {$past(q_r[WIDTH-2:0]), $past(i_serial_in_right)})
      else $error("shift right result wrong");

   par_load_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      step && mode == usr_pkg::USR_LOAD |=> q_r == $past(i_load_inputs))
      else $error("parallel load result wrong");

   no_edge_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      !step |=> $stable(o_register_outputs))
      else $error("outputs moved without a rising clock pulse");

   pre_edge_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      $rose(i_clock_pulse) |=> o_register_outputs == $past(q_nxt))
      else $error("update did not use pre-edge levels");

   clear_force_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn)
      !i_async_clear_n ##1 !i_async_clear_n |-> o_register_outputs == '0)
      else $error("outputs not low during clear");

   clear_async_a: assert property (
      @(posedge i_clock)
      $fell(i_async_clear_n) |-> q_r == '0)
      else $error("clear waited for a clock edge");

   mode_seen_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn || !i_async_clear_n)
      step |=> last_mode_r == $past(mode) ##1 $stable(last_mode_r) || $past(step))
      else $error("mode not recorded at the update");

   bresp_hold_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn)
      o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
      else $error("write response dropped before bready");

   rdata_hold_a: assert property (
      @(posedge i_clock) disable iff (!i_rstn)
      o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
      else $error("read data changed before rready");

endmodule

// [tb/usr_pin_model.sv]
// Purpose: model of the logic that drives the shift register pins
// Assumes: i_go pulsed for one cycle while o_busy is low
// Notes:   data pins turn inverted once a short pulse falls; a long pulse inverts them while high and restores them as it falls
`timescale 1ns/100ps
module usr_pin_model (
   // request side
   input  wire logic       i_clock,
   input  wire logic       i_go,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_sl,
   input  wire logic       i_sr,
   input  wire logic [3:0] i_load,
   input  wire logic       i_long,
   output logic            o_busy,
   // device pins
   output logic            o_clock_pulse,
   output logic [1:0]      o_mode,
   output logic            o_sl,
   output logic            o_sr,
   output logic [3:0]      o_load
);
   logic [1:0] ph_r;
   logic       long_r;
   initial begin
      ph_r = 2'h0;
      long_r = 1'b0;
      o_busy = 1'b0;
      o_clock_pulse = 1'b0;
      {o_mode, o_sl, o_sr, o_load} = 8'h00;
   end
   always @(posedge i_clock) begin
      case (ph_r)
         2'h0: if (i_go) begin
            {o_mode, o_sl, o_sr, o_load} <= {i_mode, i_sl, i_sr, i_load};
            o_busy <= 1'b1;
            long_r <= i_long;
            ph_r <= 2'h1;
         end
         2'h1: begin
            o_clock_pulse <= 1'b1;
            ph_r <= long_r ? 2'h3 : 2'h2;
         end
         2'h3: begin
            // pulse stays high while the data pins move
            {o_mode, o_sl, o_sr, o_load} <= ~{o_mode, o_sl, o_sr, o_load};
            ph_r <= 2'h2;
         end
         default: begin
            o_clock_pulse <= 1'b0;
            {o_mode, o_sl, o_sr, o_load} <= ~{o_mode, o_sl, o_sr, o_load};
            o_busy <= 1'b0;
            ph_r <= 2'h0;
         end
      endcase
   end
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for the shift register and its bus
// Assumes: pins but async_clear_n driven through the pin model, registers over AXI4-Lite
// Notes:   updates are logged once the log is enabled, until the 16-entry buffer is full
`timescale 1ns/100ps
`include "usr_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        clr_n = 1'b1;
   logic        go = 1'b0;
   logic [1:0]  mode = 2'h0;
   logic        sl = 1'b0;
   logic        sr = 1'b0;
   logic [3:0]  ld = 4'h0;
   logic        lng = 1'b0;
   logic        busy, cp, psl, psr, log_rdy;
   logic [1:0]  pm, bresp, rresp;
   logic [3:0]  pld, q, q_exp;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        log_on;
   logic [5:0]  logq [$];
   int          error_cnt = 0;
   int          checks = 0;
   int          i;

   always #50 clock = ~clock;

   usr_pin_model pins (.i_clock(clock), .i_go(go), .i_mode(mode), .i_sl(sl), .i_sr(sr),
      .i_load(ld), .i_long(lng), .o_busy(busy), .o_clock_pulse(cp), .o_mode(pm), .o_sl(psl),
      .o_sr(psr), .o_load(pld));

   usr_shift_top dut (.i_clock(clock), .i_rstn(rstn), .i_async_clear_n(clr_n),
      .i_clock_pulse(cp), .i_mode_select_high(pm[1]), .i_mode_select_low(pm[0]),
      .i_serial_in_left(psl), .i_serial_in_right(psr), .i_load_inputs(pld),
      .o_register_outputs(q), .o_log_ready(log_rdy),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic stop_now;
      error_cnt++;
      $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 40) stop_now();
      `CHK(bresp, e)
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 40) stop_now();
      `CHK(rdata, e)
      `CHK(rresp, er)
   endtask

   task automatic op(input logic [1:0] m, input logic l, input logic r, input logic [3:0] p);
      int n;
      @(posedge clock);
      go <= 1'b1;
      mode <= m;
      sl <= l;
      sr <= r;
      ld <= p;
      @(posedge clock);
      go <= 1'b0;
      for (n = 0; n < 10; n++) begin
         @(posedge clock);
         if (!busy) break;
      end
      if (n == 10) stop_now();
      if (clr_n) begin
         case (m)
            2'h0: ;
            2'h1: q_exp = {q_exp[2:0], r};
            2'h2: q_exp = {l, q_exp[3:1]};
            default: q_exp = p;
         endcase
         if (log_on && logq.size() < 16) logq.push_back({m, q_exp});
      end
      `CHK(q, q_exp)
   endtask

   initial begin
      q_exp = 4'h0;
      log_on = 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      `CHK(q, 4'h0)
      `CHK(log_rdy, 1'b1)
      $display("test reset done");
      op(2'h3, 1'b0, 1'b0, 4'ha);
      op(2'h0, 1'b1, 1'b1, 4'h5);
      op(2'h2, 1'b1, 1'b0, 4'h0);
      op(2'h2, 1'b0, 1'b1, 4'hf);
      op(2'h1, 1'b1, 1'b0, 4'h0);
      lng <= 1'b1;
      op(2'h1, 1'b0, 1'b1, 4'hf);
      lng <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK(q, q_exp)
      rd(`USR_ADDR_STATE, {26'h0, 2'h1, q_exp}, `USR_RESP_OKAY);
      $display("test modes done");
      @(posedge clock);
      clr_n <= 1'b0;
      #20;
      `CHK(q, 4'h0)
      q_exp = 4'h0;
      op(2'h3, 1'b1, 1'b1, 4'hf);
      @(posedge clock);
      clr_n <= 1'b1;
      op(2'h3, 1'b0, 1'b0, 4'h9);
      $display("test clear done");
      wr(`USR_ADDR_CTRL, 32'h1, `USR_RESP_OKAY);
      rd(`USR_ADDR_CTRL, 32'h1, `USR_RESP_OKAY);
      wr(`USR_ADDR_STATE, 32'h0, `USR_RESP_SLVERR);
      wr(8'h20, 32'h0, `USR_RESP_SLVERR);
      rd(8'h10, 32'h0, `USR_RESP_SLVERR);
      $display("test bus done");
      log_on = 1'b1;
      for (i = 0; i < 17; i++) op(2'(i), i[0], i[1], 4'(i * 3));
      repeat (2) @(posedge clock);
      `CHK(log_rdy, 1'b0)
      rd(`USR_ADDR_LEVEL, 32'h0001_0010, `USR_RESP_OKAY);
      while (logq.size() > 0) rd(`USR_ADDR_LOG, {23'h0, 3'h4, logq.pop_front()}, 2'b00);
      rd(`USR_ADDR_LOG, 32'h0, `USR_RESP_OKAY);
      wr(`USR_ADDR_CTRL, 32'h3, `USR_RESP_OKAY);
      rd(`USR_ADDR_LEVEL, 32'h0, `USR_RESP_OKAY);
      `CHK(log_rdy, 1'b1)
      $display("test log done");
      report_and_stop();
   end
endmodule
